// file: hw/uoe_pkg.sv
// Package for the OTG event and control slice: offsets, field positions,
// reset values, timing constants and the structs that carry bus and pins.
// Assumes a 125 MHz system clock and a 32-bit byte-addressed register port.
package uoe_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_TIME_NS    = 1_000_000;
    // Longest whole number of cycles that fits in one millisecond.
    localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
    localparam int MS_CNT_W      = 17;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_EVENT  = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_CTRL   = 8'h08;

    // ************************************************************
    // Event and enable bit positions
    // ************************************************************
    localparam int BIT_ID       = 7;
    localparam int BIT_MS       = 6;
    localparam int BIT_LINE     = 5;
    localparam int BIT_ACT      = 4;
    localparam int BIT_SDROP    = 3;
    localparam int BIT_BSEND    = 2;
    localparam int BIT_AVALID   = 0;
    localparam logic [7:0] EVENT_MASK = 8'hFD;

    // ************************************************************
    // Control bit positions
    // ************************************************************
    localparam int CTL_ON       = 0;
    localparam int CTL_PPRST    = 1;
    localparam int CTL_RESUME   = 2;
    localparam int CTL_HOST     = 3;
    localparam int CTL_TKBUSY   = 5;
    localparam logic [7:0] CTRL_WR_MASK = 8'h0F;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Register port request from software.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } uoe_bus_type;

    // Cable-side pins and comparator levels, all asynchronous.
    typedef struct packed {
        logic       id;
        logic [1:0] line_state;
        logic       vbus_valid;
        logic       sess_end;
    } uoe_pins_type;

endpackage

// file: hw/uoe_sync2.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes the inputs are levels that stay put for several clock cycles.
`timescale 1ns/1ns
module uoe_sync2
    import uoe_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // First stage is read only by the second stage.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

// file: hw/uoe_line_stable.sv
// Line-state stability watcher: pulses when the line state has held one
// value for a full millisecond and that value differs from the last one
// reported. Assumes a synchronised line state on the system clock.
`timescale 1ns/1ns
module uoe_line_stable
    import uoe_pkg::*;
#(
    parameter int MS_LEN = MS_CYCLES
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    input  wire logic [1:0] line_in,
    output logic            change_out
);

    logic [1:0]          line_q;
    logic [1:0]          reported;
    logic [MS_CNT_W-1:0] hold_cnt;
    wire                 moved   = (line_in != line_q);
    wire                 matured = (hold_cnt == MS_CNT_W'(MS_LEN - 1));

    // Count cycles of unchanged line state, report a new stable value once.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            line_q     <= 2'h0;
            reported   <= 2'h0;
            hold_cnt   <= '0;
            change_out <= 1'b0;
        end else begin
            line_q     <= line_in;
            change_out <= 1'b0;
            if (moved) begin
                hold_cnt <= '0;
            end else if (!matured) begin
                hold_cnt <= hold_cnt + 1'b1;
            end else if (line_q != reported) begin
                reported   <= line_q;
                change_out <= 1'b1;
            end
        end
    end

endmodule

// file: hw/uoe_event_ctrl.sv
// OTG event flags, event enables and main control slice of a USB OTG
// controller, with its register port.
// Assumes cable pins arrive asynchronously and are synchronised here, and
// that sleep and token-busy indications come from logic on the same clock.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module uoe_event_ctrl
    import uoe_pkg::*;
#(
    parameter int MS_LEN = MS_CYCLES
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    input  wire uoe_bus_type  bus_in,
    output logic [31:0]       rdata_out,
    input  wire uoe_pins_type pins_in,
    input  wire logic         sleep_in,
    input  wire logic         token_busy_in,
    output logic              irq_out,
    output logic              module_on_out,
    output logic              pp_reset_out,
    output logic              frame_token_out,
    output logic              host_reset_out,
    output logic              resume_drive_out,
    output logic              resume_eop_out
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************

    logic [4:0] pins_s;
    logic       id_s;
    logic [1:0] line_s;
    logic       vbus_valid_s;
    logic       sess_end_s;

    // Every cable level passes two flip-flops before any logic reads it.
    // Two stages suffice, as cable levels move slowly against the clock.
    uoe_sync2 #(
        .WIDTH (5)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   (pins_in),
        .sync_out   (pins_s)
    );

    // Split the synchronised vector back into named levels.
    assign id_s         = pins_s[4];
    assign line_s       = pins_s[3:2];
    assign vbus_valid_s = pins_s[1];
    assign sess_end_s   = pins_s[0];

    // ************************************************************
    // Previous levels for change detection
    // ************************************************************

    logic       id_q;
    logic [1:0] line_q;
    logic       vbus_valid_q;
    logic       sess_end_q;
    logic [2:0] prime_sr;
    wire        pins_primed = prime_sr[2];

    // Hold last synchronised levels. The synchroniser shows its reset zeros
    // for two cycles after reset, so change detection waits three cycles;
    // a pin already high at reset would otherwise look like a fresh edge.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            id_q         <= 1'b0;
            line_q       <= 2'h0;
            vbus_valid_q <= 1'b0;
            sess_end_q   <= 1'b0;
            prime_sr     <= 3'h0;
        end else begin
            id_q         <= id_s;
            line_q       <= line_s;
            vbus_valid_q <= vbus_valid_s;
            sess_end_q   <= sess_end_s;
            prime_sr     <= {prime_sr[1:0], 1'b1};
        end
    end

    // ************************************************************
    // Millisecond timer
    // ************************************************************

    logic [MS_CNT_W-1:0] ms_cnt;
    wire                 ms_tick = (ms_cnt == MS_CNT_W'(MS_LEN - 1));

    // Free-running divider that marks each millisecond with one pulse.
    // It never stops, so frame tokens keep one grid across mode changes.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ms_cnt <= '0;
        end else if (ms_tick) begin
            ms_cnt <= '0;
        end else begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end

    // ************************************************************
    // Line-state stability
    // ************************************************************

    logic line_event;

    // The watcher keeps its own history, apart from the wake detector.
    // line stable watch
    uoe_line_stable #(
        .MS_LEN (MS_LEN)
    ) u_line (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .line_in    (line_s),
        .change_out (line_event)
    );

    // ************************************************************
    // Event sources
    // ************************************************************

    logic [7:0] ev_set;
    wire        id_moved   = pins_primed & (id_s ^ id_q);
    wire        line_moved = pins_primed & (line_s != line_q);
    wire        vb_moved   = pins_primed & (vbus_valid_s ^ vbus_valid_q);
    wire        se_moved   = pins_primed & (sess_end_s ^ sess_end_q);
    wire        se_rise    = se_moved & sess_end_s;
    wire        any_moved  = id_moved | line_moved | vb_moved | se_moved;

    // Gather the one-cycle set requests at their flag positions.
    // A rising session end level means the supply fell below that level.
    // Any synchronised pin change counts as wake activity while asleep.
    always_comb begin
        ev_set = 8'h00;
        ev_set[BIT_ID] = id_moved;
        ev_set[BIT_MS] = ms_tick;
        ev_set[BIT_LINE] = line_event;
        ev_set[BIT_ACT] = sleep_in & any_moved;
        ev_set[BIT_SDROP] = se_rise;
        ev_set[BIT_BSEND] = se_moved;
        ev_set[BIT_AVALID] = vb_moved;
    end

    // ************************************************************
    // Register decode
    // ************************************************************

    logic [7:0] ev_flags;
    logic [7:0] ev_enables;
    logic [7:0] ctrl;

    // Exact offset match, shared by the write strobes and the read mux.
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return (addr == ofs);
    endfunction

    // Other offsets are ignored on write and read back as zero.
    wire hit_event  = reg_hit(bus_in.addr, OFS_EVENT);
    wire hit_enable = reg_hit(bus_in.addr, OFS_ENABLE);
    wire hit_ctrl   = reg_hit(bus_in.addr, OFS_CTRL);
    wire wr_event   = bus_in.wr & hit_event;
    wire wr_enable  = bus_in.wr & hit_enable;
    wire wr_ctrl    = bus_in.wr & hit_ctrl;

    // ************************************************************
    // Event flags
    // ************************************************************

    logic [7:0] flag_clear;
    logic [7:0] next_flags;

    assign flag_clear = wr_event ? (bus_in.wdata[7:0] & EVENT_MASK) : 8'h00;

    // Per-bit sticky flags; a set in the clear cycle wins.
    // Bit 1 is masked off, so it can never be set or read as one.
    generate
        for (genvar i = 0; i < 8; i++) begin : g_flag
            assign next_flags[i] = EVENT_MASK[i] &
                                   (ev_set[i] | (ev_flags[i] & ~flag_clear[i]));
        end
    endgenerate

    // Flag register, all zero after reset.
    // Reads have no side effect; only a written one clears a flag.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ev_flags <= RST_BYTE;
        end else begin
            ev_flags <= next_flags;
        end
    end

    // ************************************************************
    // Event enables
    // ************************************************************

    // Unused positions are masked so that they always read as zero.
    // enable bits
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ev_enables <= RST_BYTE;
        end else if (wr_enable) begin
            ev_enables <= bus_in.wdata[7:0] & EVENT_MASK;
        end
    end

    // The request is a level that drops when software clears or masks it.
    // masked interrupt
    assign irq_out = |(ev_flags & ev_enables);

    // ************************************************************
    // Main control
    // ************************************************************

    logic [7:0] next_ctrl;
    wire        host_mode = ctrl[CTL_HOST];

    // Only the writable control bits take new values.
    // Bit 5 is dropped on write; it only mirrors the token engine.
    assign next_ctrl = wr_ctrl ? (bus_in.wdata[7:0] & CTRL_WR_MASK) : ctrl;

    // Control register, all zero after reset.
    // A write takes effect at the edge that samples its strobe.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ctrl <= RST_BYTE;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // In host mode bit 0 serves as the frame token enable instead.
    // device mode enable
    assign module_on_out = ctrl[CTL_ON] & ~host_mode;

    // A level: the pointer logic outside stays on the even bank while high.
    // pointers to even
    assign pp_reset_out = ctrl[CTL_PPRST];

    // Resume stays driven as long as software holds the bit.
    // Its length is up to software; the block only mirrors the bit.
    assign resume_drive_out = ctrl[CTL_RESUME];

    // ************************************************************
    // Host-side sequencing
    // ************************************************************

    // Both edges compare the current bit with the value about to be written.
    logic frame_q;
    logic host_rst_q;
    logic eop_q;
    wire  host_flip = host_mode ^ next_ctrl[CTL_HOST];
    wire  resume_off = ctrl[CTL_RESUME] & ~next_ctrl[CTL_RESUME];

    // Registered one-cycle pulses towards the host engine.
    // A host mode flip either way resets the host engine for one cycle.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            frame_q    <= 1'b0;
            host_rst_q <= 1'b0;
            eop_q      <= 1'b0;
        end else begin
            frame_q    <= host_mode & ctrl[CTL_ON] & ms_tick;
            host_rst_q <= host_flip;
            eop_q      <= host_mode & resume_off;
        end
    end

    assign frame_token_out = frame_q;
    assign host_reset_out  = host_rst_q;
    assign resume_eop_out  = eop_q;

    // ************************************************************
    // Read path
    // ************************************************************

    logic [31:0] read_word;
    logic [31:0] rdata_q;
    logic [7:0]  ctrl_view;

    // Software polls bit 5 before it hands over another token.
    // token busy view
    always_comb begin
        ctrl_view = ctrl;
        ctrl_view[CTL_TKBUSY] = token_busy_in;
    end

    // Unmapped offsets fall through to a zero word.
    // upper bits zero
    assign read_word = hit_event  ? {24'h00_0000, ev_flags & EVENT_MASK} :
                       hit_enable ? {24'h00_0000, ev_enables & EVENT_MASK} :
                       hit_ctrl   ? {24'h00_0000, ctrl_view} :
                                    RST_WORD;

    // Read data stand in the cycle after the strobe and only there.
    // Falling back to zero keeps a stale word from passing as a read.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rdata_q <= RST_WORD;
        end else if (bus_in.rd) begin
            rdata_q <= read_word;
        end else begin
            rdata_q <= RST_WORD;
        end
    end

    assign rdata_out = rdata_q;

endmodule

// file: bench/uoe_cable_model.sv
// Cable-side model: drives the identification, line-state and comparator
// levels seen by the block. Assumes the bench calls drive to change them.
`timescale 1ns/1ns
module uoe_cable_model
    import uoe_pkg::*;
(
    output uoe_pins_type pins_out
);
    // ************************************************************
    // Pin levels
    // ************************************************************
    uoe_pins_type lvl = '0;

    // Comparator and line levels are real levels, never released.
    assign pins_out = lvl;

    // Applies a new set of cable levels.
    task automatic drive(input uoe_pins_type v);
        lvl <= v;
    endtask
endmodule

// file: bench/uoe_event_ctrl_chk.sv
// Checker for the OTG event and control slice, bound to its top module.
// Assumes no bus request is made while reset is low.
`timescale 1ns/1ns
module uoe_event_ctrl_chk
    import uoe_pkg::*;
#(
    parameter int MS_LEN = MS_CYCLES
) (
    input wire logic         clk_sys_in,
    input wire logic         rst_n_in,
    input wire uoe_bus_type  bus_in,
    input wire logic [31:0]  rdata_out,
    input wire logic         irq_out,
    input wire logic         module_on_out,
    input wire logic         pp_reset_out,
    input wire logic         frame_token_out,
    input wire logic         host_reset_out,
    input wire logic         resume_drive_out,
    input wire logic         resume_eop_out
);
    // ************************************************************
    // Helper logic
    // ************************************************************
    logic [31:0] gap;
    logic        seen;
    wire         ctl_wr = bus_in.wr && (bus_in.addr == OFS_CTRL);

    // Counts cycles since the last frame token.
    always_ff @(posedge clk_sys_in) begin
        gap <= (!rst_n_in || frame_token_out) ? 32'h0000_0000 : gap + 32'h0000_0001;
        seen <= rst_n_in && (seen || frame_token_out);
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_RD_IDLE: assert property (!$past(bus_in.rd) |-> rdata_out == '0)
        else $error("read data not zero outside a read");
    AST_HIGH_ZERO: assert property ($past(bus_in.rd) |-> rdata_out[31:8] == '0)
        else $error("upper read bits not zero");
    AST_BIT1_ZERO: assert property ($past(bus_in.rd) && $past(bus_in.addr) != OFS_CTRL
        |-> !rdata_out[1]) else $error("bit 1 of flags or enables not zero");
    AST_CTL_HOLD: assert property (!$past(ctl_wr)
        |-> $stable(module_on_out) && $stable(pp_reset_out)) else $error("control moved alone");
    AST_ON_VALUE: assert property ($past(ctl_wr) |-> module_on_out ==
        ($past(bus_in.wdata[CTL_ON]) && !$past(bus_in.wdata[CTL_HOST])))
        else $error("module enable wrong after write");
    AST_PP_VALUE: assert property ($past(ctl_wr) |-> pp_reset_out ==
        $past(bus_in.wdata[CTL_PPRST]) && resume_drive_out == $past(bus_in.wdata[CTL_RESUME]))
        else $error("pointer reset or resume wrong after write");
    AST_HOST_RST: assert property (host_reset_out |-> $past(ctl_wr) ##1 !host_reset_out)
        else $error("host reset pulse without control write");
    AST_EOP: assert property (resume_eop_out |-> $past(ctl_wr) && $past(resume_drive_out)
        && !$past(bus_in.wdata[CTL_RESUME])) else $error("end of packet without resume clear");
    AST_FRAME_GAP: assert property (frame_token_out && seen |-> ((gap + 1) % MS_LEN) == 0)
        else $error("frame token off the millisecond grid");
    AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(bus_in.wr))
        else $error("interrupt request fell without a write");
endmodule

bind uoe_event_ctrl uoe_event_ctrl_chk #(.MS_LEN(MS_LEN)) i_uoe_event_ctrl_chk (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .module_on_out(module_on_out), .pp_reset_out(pp_reset_out),
    .frame_token_out(frame_token_out), .host_reset_out(host_reset_out),
    .resume_drive_out(resume_drive_out), .resume_eop_out(resume_eop_out)
);

// file: bench/uoe_event_ctrl_tb_top.sv
// Self-checking bench for the OTG event and control slice.
// Assumes a 50-cycle millisecond and the cable model on the pins.
`timescale 1ns/1ns
module uoe_event_ctrl_tb_top
    import uoe_pkg::*;
();
    localparam int          MSL = 50;
    localparam logic [31:0] NMS = 32'hFFFF_FFBF;
    logic         clk_sys_in = 1'b0;
    logic         rst_n_in = 1'b0;
    uoe_bus_type  bus = '0;
    uoe_pins_type pins;
    uoe_pins_type p = '0;
    logic         sleep = 1'b0;
    logic         busy = 1'b0;
    logic [31:0]  rdata;
    logic         irq, mon, ppr, ftok, hrst, rdrv, reop;
    int           bad_count = 0;
    int           n_checks = 0;
    int           n_ftok = 0;
    int           n_hrst = 0;
    int           n_eop = 0;
    int           c0;

    // ************************************************************
    // Clock, pulse counters and instances
    // ************************************************************
    always #4 clk_sys_in = ~clk_sys_in;

    // Counts the one-cycle pulses.
    always @(posedge clk_sys_in) begin
        n_ftok += (ftok === 1'b1);
        n_hrst += (hrst === 1'b1);
        n_eop += (reop === 1'b1);
    end

    uoe_cable_model i_uoe_cable_model (.pins_out(pins));
    uoe_event_ctrl #(.MS_LEN(MSL)) i_uoe_event_ctrl (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata),
        .pins_in(pins), .sleep_in(sleep), .token_busy_in(busy), .irq_out(irq),
        .module_on_out(mon), .pp_reset_out(ppr), .frame_token_out(ftok),
        .host_reset_out(hrst), .resume_drive_out(rdrv), .resume_eop_out(reop)
    );

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys_in);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_sys_in);
        bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk_sys_in);
        bus.rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask

    // Applies new cable levels and lets them cross the synchroniser.
    task automatic cable();
        @(posedge clk_sys_in);
        i_uoe_cable_model.drive(p);
        repeat (6) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic frames(input int exp);
        @(posedge clk_sys_in);
        #1 c0 = n_ftok;
        repeat (3 * MSL) @(posedge clk_sys_in);
        #1 chk(n_ftok - c0, exp);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        rdc(OFS_EVENT, '1, '0);
        rdc(OFS_ENABLE, '1, '0);
        rdc(8'h0C, '1, '0);
        wr(OFS_ENABLE, 32'hFFFF_FFFF);
        rdc(OFS_ENABLE, '1, 32'h0000_00FD);
        wr(OFS_ENABLE, 32'h0000_0000);
        rdc(OFS_ENABLE, '1, '0);
    endtask

    task automatic t_flags();
        p.id = 1'b1;
        cable();
        rdc(OFS_EVENT, NMS, 32'h0000_0080);
        wr(OFS_EVENT, 32'h0000_007F);
        rdc(OFS_EVENT, NMS, 32'h0000_0080);
        wr(OFS_EVENT, 32'h0000_0080);
        rdc(OFS_EVENT, NMS, '0);
        p.sess_end = 1'b1;
        cable();
        rdc(OFS_EVENT, NMS, 32'h0000_000C);
        wr(OFS_EVENT, 32'h0000_00FF);
        p.sess_end = 1'b0;
        cable();
        rdc(OFS_EVENT, NMS, 32'h0000_0004);
        p.vbus_valid = 1'b1;
        wr(OFS_EVENT, 32'h0000_00FF);
        cable();
        rdc(OFS_EVENT, NMS, 32'h0000_0001);
        sleep <= 1'b1;
        p.vbus_valid = 1'b0;
        wr(OFS_EVENT, 32'h0000_00FF);
        cable();
        rdc(OFS_EVENT, NMS, 32'h0000_0011);
        sleep <= 1'b0;
        wr(OFS_EVENT, 32'h0000_00FF);
        repeat (MSL + 5) @(posedge clk_sys_in);
        rdc(OFS_EVENT, 32'h0000_0040, 32'h0000_0040);
    endtask

    task automatic t_line();
        p.line_state = 2'b01;
        cable();
        repeat (MSL + 5) @(posedge clk_sys_in);
        rdc(OFS_EVENT, 32'h0000_0020, 32'h0000_0020);
        wr(OFS_EVENT, 32'h0000_0020);
        repeat (MSL + 10) @(posedge clk_sys_in);
        rdc(OFS_EVENT, 32'h0000_0020, '0);
    endtask

    task automatic t_irq();
        wr(OFS_ENABLE, 32'h0000_0080);
        p.id = 1'b0;
        cable();
        chk(irq, 1'b1);
        wr(OFS_ENABLE, 32'h0000_0000);
        chk(irq, 1'b0);
        wr(OFS_ENABLE, 32'h0000_0080);
        chk(irq, 1'b1);
        wr(OFS_EVENT, 32'h0000_0080);
        chk(irq, 1'b0);
    endtask

    task automatic t_ctrl();
        busy <= 1'b1;
        wr(OFS_CTRL, 32'hFFFF_FFFF);
        rdc(OFS_CTRL, '1, 32'h0000_002F);
        busy <= 1'b0;
        wr(OFS_CTRL, 32'h0000_0001);
        chk({ppr, mon}, 2'b01);
        wr(OFS_CTRL, 32'h0000_0002);
        chk({ppr, mon}, 2'b10);
        c0 = n_hrst;
        wr(OFS_CTRL, 32'h0000_0008);
        wr(OFS_CTRL, 32'h0000_0009);
        wr(OFS_CTRL, 32'h0000_0000);
        repeat (2) @(posedge clk_sys_in);
        #1 chk(n_hrst - c0, 2);
    endtask

    task automatic t_frame();
        wr(OFS_CTRL, 32'h0000_0001);
        frames(0);
        wr(OFS_CTRL, 32'h0000_0009);
        frames(3);
        @(posedge clk_sys_in iff ftok === 1'b1);
        repeat (MSL - 3) @(posedge clk_sys_in);
        wr(OFS_EVENT, 32'h0000_0040);
        rdc(OFS_EVENT, 32'h0000_0040, 32'h0000_0040);
        wr(OFS_CTRL, 32'h0000_0008);
        frames(0);
    endtask

    task automatic t_resume();
        c0 = n_eop;
        wr(OFS_CTRL, 32'h0000_0004);
        repeat (10 * MSL) @(posedge clk_sys_in);
        #1 chk(rdrv, 1'b1);
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0008);
        wr(OFS_CTRL, 32'h0000_000C);
        repeat (25 * MSL) @(posedge clk_sys_in);
        #1 chk(rdrv, 1'b1);
        wr(OFS_CTRL, 32'h0000_0008);
        repeat (2) @(posedge clk_sys_in);
        #1 chk(n_eop - c0, 1);
    endtask

    task automatic t_reset();
        p.id = 1'b1;
        p.vbus_valid = 1'b1;
        cable();
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        rdc(OFS_EVENT, 32'h0000_009D, '0);
        rdc(OFS_ENABLE, '1, '0);
        rdc(OFS_CTRL, 32'h0000_000F, '0);
    endtask

    // ************************************************************
    // Verdict, watchdog and main sequence
    // ************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the few thousand cycles needed.
    initial begin
        #(8 * 20000);
        bad_count++;
        print_verdict();
    end

    // Holds reset for three cycles, then runs every scenario.
    initial begin
        repeat (3) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_flags();
        t_line();
        t_irq();
        t_ctrl();
        t_frame();
        t_resume();
        t_reset();
        print_verdict();
    end
endmodule
